// ---- rtl/apem_cfg.svh ----
// apem_cfg.svh: offsets, field positions and counts of the audio port error monitor
// assumes: included by the package, apem_clk_mon and apem_err_mon; apem_sync2 does not include it
`ifndef APEM_CFG_SVH
`define APEM_CFG_SVH

`define APEM_NSER        4
`define APEM_AW          8
`define APEM_GROUP_LAST  5'h1F
`define APEM_CNT_SAT     8'hFF
`define APEM_PRE_ONES    7'h7F
`define APEM_BP_ZERO_BITS 3'h4

`define APEM_OFF_TXCHK   8'h00
`define APEM_OFF_RXCHK   8'h04
`define APEM_OFF_TXSTAT  8'h08
`define APEM_OFF_RXSTAT  8'h0C
`define APEM_OFF_TXINT   8'h10
`define APEM_OFF_RXINT   8'h14
`define APEM_OFF_MUTE    8'h18
`define APEM_OFF_CFG     8'h1C

`define APEM_F_MIN       7:0
`define APEM_F_MAX       15:8
`define APEM_F_PS        18:16
`define APEM_F_SW        19
`define APEM_F_CNT       31:24
`define APEM_F_FLAGS     3:0
`define APEM_F_TXMUTE    3:0
`define APEM_F_RXMUTE    7:4
`define APEM_F_MUTELOW   8
`define APEM_F_INPOLLOW  9
`define APEM_F_INEN      10
`define APEM_F_TDM       0
`define APEM_F_BIPHASE   1
`define APEM_F_RESTART   2
`define APEM_F_FLEN      26:16

`define APEM_ST_XRUN     0
`define APEM_ST_SYNC     1
`define APEM_ST_CKF      2
`define APEM_ST_DMA      3

`endif

// ---- rtl/apem_clk_mon.sv ----
// apem_clk_mon: counts prescaled system clocks over every 32 periods of a serial clock pin
// assumes: bounds come from flops on clk; hf_pin is asynchronous to clk
`timescale 1ns/1ps
`include "apem_cfg.svh"
module apem_clk_mon (
   input  wire logic              clk,
   input  wire logic              arst_n,
   input  wire logic              hf_pin,
   input  wire apem_pkg::apem_chk_s chk,
   output logic [7:0]             count,
   output logic                   fail
);
   import apem_pkg::*;
   apem_mon_s  s_r;
   apem_mon_s  s_nxt;
   logic       hf_s;
   logic       rise;
   logic [6:0] mask;

   apem_sync2 u_sync (.clk(clk), .arst_n(arst_n), .d(hf_pin), .q(hf_s)); // see [RULE_25]

   always_comb begin
      s_nxt      = s_r;
      s_nxt.fail = 1'b0;
      s_nxt.hf_d = hf_s;
      rise       = hf_s & ~s_r.hf_d;
      mask       = ~(`APEM_PRE_ONES << chk.ps);
      s_nxt.pre  = s_r.pre + 7'h01;
      if (((s_r.pre & mask) == mask) && (s_r.run_cnt != `APEM_CNT_SAT)) begin
         s_nxt.run_cnt = s_r.run_cnt + 8'h01;
      end
      if (rise) begin
         s_nxt.edges = s_r.edges + 5'h01;
         if (s_r.edges == `APEM_GROUP_LAST) begin
            s_nxt.count   = s_r.run_cnt;                       // see [RULE_01] see [RULE_02]
            s_nxt.run_cnt = '0;
            s_nxt.pre     = '0;
            if (s_r.run_cnt < chk.min_b) begin
               s_nxt.fail = 1'b1;                              // see [RULE_03] see [RULE_05]
            end
         end
      end
      if (s_r.run_cnt > chk.max_b) begin
         s_nxt.fail = 1'b1;                                    // see [RULE_04] see [RULE_05]
      end
   end

   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         s_r <= '0;
      end else begin
         s_r <= s_nxt;
      end
   end

   assign count = s_r.count;
   assign fail  = s_r.fail;

   group_latch_a: assert property (@(posedge clk) disable iff (!arst_n) // see [RULE_01]
      (hf_s && !s_r.hf_d && s_r.edges == `APEM_GROUP_LAST)
         |=> (s_r.count == $past(s_r.run_cnt) && s_r.run_cnt == 8'h00))
      else $error("count not latched at group end");

   max_bound_a: assert property (@(posedge clk) disable iff (!arst_n) // see [RULE_04]
      (s_r.run_cnt > chk.max_b) |=> s_r.fail)
      else $error("running count above max not flagged");
endmodule // apem_clk_mon

// ---- rtl/apem_err_mon.sv ----
// apem_err_mon: error detection and management of a multichannel audio serial port
// assumes: link strobes are one-clk pulses from serializer logic on clk;
// serial clock pins and the external mute pin are asynchronous to clk
//
// Contract
// [RULE_01] latch tx count every 32 serial clocks
// [RULE_02] latch rx count every 32 serial clocks
// [RULE_03] latched count below min sets fail
// [RULE_04] running count above max sets fail
// [RULE_05] bounds eight bit, compared unsigned
// [RULE_06] clock fail interrupts only when enabled
// [RULE_07] software releases serial clock divider first
// [RULE_08] software runs startup loop before enabling
// [RULE_09] burst: early sync is unexpected
// [RULE_10] tdm: sync only exactly before slot 0
// [RULE_11] early sync: flag, finish frame, resync later
// [RULE_12] gap after frame: flag, resync next sync
// [RULE_13] late sync detected same in both modes
// [RULE_14] load from unwritten buffer sets underrun
// [RULE_15] underrun once per slot, write one clears
// [RULE_16] biphase underrun sends four zero bit times
// [RULE_17] tdm underrun sends zeros until restart
// [RULE_18] unread buffer overwritten sets overrun
// [RULE_19] overrun sticky until write one clears
// [RULE_20] extra transmit dma words set dma error
// [RULE_21] extra receive dma reads set dma error
// [RULE_22] selected errors or mute input drive mute
// [RULE_23] interrupt only when enable set, flag pollable
// [RULE_24] mute holds until flags cleared, input idle
// [RULE_25] serial clock synchronised before counting
`timescale 1ns/1ps
`include "apem_cfg.svh"
module apem_err_mon (
   input  wire logic                   clk,
   input  wire logic                   arst_n,
   input  wire logic [`APEM_AW-1:0]    reg_addr,
   input  wire logic [31:0]            reg_wdata,
   input  wire logic                   reg_wr,
   input  wire logic                   reg_rd,
   output logic [31:0]                 reg_rdata,
   input  wire logic                   tx_hf_serial_clock,
   input  wire logic                   rx_hf_serial_clock,
   input  wire logic                   external_mute_input,
   input  wire apem_pkg::apem_dir_in_s tx_link,
   input  wire apem_pkg::apem_dir_in_s rx_link,
   output logic                        tx_irq,
   output logic                        rx_irq,
   output logic                        mute_output,
   output logic                        tx_clk_switch,
   output logic                        tx_zero_fill
);
   import apem_pkg::*;

   typedef struct packed {
      apem_chk_s              tx_chk;
      apem_chk_s              rx_chk;
      logic [3:0]             tx_stat;
      logic [3:0]             rx_stat;
      logic [3:0]             tx_ie;
      logic [3:0]             rx_ie;
      logic [3:0]             tx_mute_en;
      logic [3:0]             rx_mute_en;
      logic                   mute_low;
      logic                   in_pol_low;
      logic                   in_en;
      logic                   tdm;
      logic                   biphase;
      logic [10:0]            frame_len;
      apem_frame_s            tx_fr;
      apem_frame_s            rx_fr;
      logic [`APEM_NSER-1:0]  tx_written;
      logic [`APEM_NSER-1:0]  rx_unread;
      logic [2:0]             tx_words;
      logic [2:0]             rx_words;
      logic                   zero_hold;
      logic [2:0]             bp_left;
      logic                   zero_fill;
      logic [31:0]            rdata;
      logic                   tx_irq;
      logic                   rx_irq;
      logic                   mute;
      logic                   clk_switch;
   } apem_state_s;

   apem_state_s st_r;
   apem_state_s st_nxt;
   logic [7:0]  tx_count;
   logic [7:0]  rx_count;
   logic        tx_fail;
   logic        rx_fail;
   logic        ext_mute_s;
   logic        tx_sync_err;
   logic        rx_sync_err;
   logic        tx_undrn;
   logic        rx_ovrn;
   logic        tx_dma_err;
   logic        rx_dma_err;
   logic        ext_act;
   logic        mute_act;
   logic        restart;
   logic [3:0]  tx_clr;
   logic [3:0]  rx_clr;

   apem_clk_mon u_tx_mon (
      .clk    (clk),
      .arst_n (arst_n),
      .hf_pin (tx_hf_serial_clock),
      .chk    (st_r.tx_chk),
      .count  (tx_count),
      .fail   (tx_fail)
   );

   apem_clk_mon u_rx_mon (
      .clk    (clk),
      .arst_n (arst_n),
      .hf_pin (rx_hf_serial_clock),
      .chk    (st_r.rx_chk),
      .count  (rx_count),
      .fail   (rx_fail)
   );

   apem_sync2 u_mute_sync (.clk(clk), .arst_n(arst_n), .d(external_mute_input), .q(ext_mute_s));

   // one bit-clock step of the frame tracker; counts from the frame sync; a sync that
   // comes late is flagged as a gap and the count restarts from that sync
   function automatic apem_frame_s frame_step(input apem_frame_s fr, input logic tick,
                                              input logic fs, input logic [10:0] len,
                                              output logic err);
      apem_frame_s f;
      f   = fr;
      err = 1'b0;
      if (tick) begin
         if (fs) begin
            if (fr.active && (fr.pos != len)) begin
               err       = 1'b1;                               // see [RULE_09] see [RULE_10]
               f.wait_rs = 1'b1;                               // see [RULE_11]
               f.pos     = fr.pos + 11'h001;
            end else begin
               f.active  = 1'b1;
               f.pos     = 11'h001;
               f.wait_rs = 1'b0;
            end
         end else if (fr.active) begin
            if (fr.pos == len) begin
               err      = ~fr.wait_rs;                         // see [RULE_12] see [RULE_13]
               f.active = 1'b0;
            end else begin
               f.pos = fr.pos + 11'h001;
            end
         end
      end
      return f;
   endfunction

   function automatic logic [2:0] ones(input logic [`APEM_NSER-1:0] v);
      logic [2:0] n;
      n = '0;
      for (int i = 0; i < `APEM_NSER; i++) begin
         n = n + {2'b00, v[i]};
      end
      return n;
   endfunction

   // words moved for the current dma request; more than one per enabled serializer is an error
   function automatic logic [2:0] dma_count(input logic [2:0] words, input apem_dir_in_s l,
                                            output logic err);
      logic [2:0] w;
      w   = l.dma_req ? 3'h0 : words;
      err = 1'b0;
      if (l.dma_acc) begin
         err = (w >= ones(l.ser_en));
         if (w != 3'h7) begin
            w = w + 3'h1;
         end
      end
      return w;
   endfunction

   always_comb begin
      st_nxt = st_r;
      restart = reg_wr && (reg_addr == `APEM_OFF_CFG) && reg_wdata[`APEM_F_RESTART];
      tx_clr  = (reg_wr && (reg_addr == `APEM_OFF_TXSTAT)) ? reg_wdata[`APEM_F_FLAGS] : 4'h0;
      rx_clr  = (reg_wr && (reg_addr == `APEM_OFF_RXSTAT)) ? reg_wdata[`APEM_F_FLAGS] : 4'h0;

      st_nxt.tx_fr = frame_step(st_r.tx_fr, tx_link.bit_tick, tx_link.fsync, st_r.frame_len,
                                tx_sync_err);
      st_nxt.rx_fr = frame_step(st_r.rx_fr, rx_link.bit_tick, rx_link.fsync, st_r.frame_len,
                                rx_sync_err);

      // one check per slot transfer
      tx_undrn = tx_link.slot_xfer && |(tx_link.ser_en & ~st_r.tx_written); // see [RULE_14]
      rx_ovrn  = rx_link.slot_xfer && |(rx_link.ser_en & st_r.rx_unread);   // see [RULE_18]
      st_nxt.tx_written = (st_r.tx_written & ~(tx_link.ser_en & {`APEM_NSER{tx_link.slot_xfer}}))
                          | tx_link.buf_acc;
      // new sample overwrites the unread one; shifting never stalls
      st_nxt.rx_unread  = (st_r.rx_unread & ~rx_link.buf_acc)
                          | (rx_link.ser_en & {`APEM_NSER{rx_link.slot_xfer}});

      st_nxt.tx_words = dma_count(st_r.tx_words, tx_link, tx_dma_err); // see [RULE_20]
      st_nxt.rx_words = dma_count(st_r.rx_words, rx_link, rx_dma_err); // see [RULE_21]

      // sticky flags: set wins over a write-one clear in the same cycle
      st_nxt.tx_stat = (st_r.tx_stat & ~tx_clr)                          // see [RULE_15]
                       | {tx_dma_err, tx_fail, tx_sync_err, tx_undrn};
      st_nxt.rx_stat = (st_r.rx_stat & ~rx_clr)                          // see [RULE_19]
                       | {rx_dma_err, rx_fail, rx_sync_err, rx_ovrn};

      // zero fill after underrun: four biphase zero bit times, or zeros until restart in tdm
      if (st_r.bp_left != 3'h0 && tx_link.bit_tick) begin
         st_nxt.bp_left = st_r.bp_left - 3'h1;
      end
      if (tx_undrn && st_r.biphase) begin
         st_nxt.bp_left = `APEM_BP_ZERO_BITS;                            // see [RULE_16]
      end
      if (restart) begin
         st_nxt.zero_hold = 1'b0;
      end else if (tx_undrn && st_r.tdm && !st_r.biphase) begin
         st_nxt.zero_hold = 1'b1;                                        // see [RULE_17]
      end
      st_nxt.zero_fill = st_nxt.zero_hold || (st_nxt.bp_left != 3'h0);

      st_nxt.tx_irq = |(st_nxt.tx_stat & st_r.tx_ie);                    // see [RULE_06] see [RULE_23]
      st_nxt.rx_irq = |(st_nxt.rx_stat & st_r.rx_ie);                    // see [RULE_06] see [RULE_23]

      ext_act  = st_r.in_en && (ext_mute_s ^ st_r.in_pol_low);
      mute_act = ext_act || |(st_r.tx_stat & st_r.tx_mute_en)            // see [RULE_22]
                 || |(st_r.rx_stat & st_r.rx_mute_en);                   // see [RULE_24]
      st_nxt.mute       = mute_act ^ st_r.mute_low;
      st_nxt.clk_switch = st_r.tx_chk.sw && st_r.tx_stat[`APEM_ST_CKF];

      if (reg_wr) begin
         unique case (reg_addr)
            `APEM_OFF_TXCHK: begin
               st_nxt.tx_chk.min_b = reg_wdata[`APEM_F_MIN];
               st_nxt.tx_chk.max_b = reg_wdata[`APEM_F_MAX];
               st_nxt.tx_chk.ps    = reg_wdata[`APEM_F_PS];
               st_nxt.tx_chk.sw    = reg_wdata[`APEM_F_SW];
            end
            `APEM_OFF_RXCHK: begin
               st_nxt.rx_chk.min_b = reg_wdata[`APEM_F_MIN];
               st_nxt.rx_chk.max_b = reg_wdata[`APEM_F_MAX];
               st_nxt.rx_chk.ps    = reg_wdata[`APEM_F_PS];
            end
            `APEM_OFF_TXINT: st_nxt.tx_ie = reg_wdata[`APEM_F_FLAGS];
            `APEM_OFF_RXINT: st_nxt.rx_ie = reg_wdata[`APEM_F_FLAGS];
            `APEM_OFF_MUTE: begin
               st_nxt.tx_mute_en = reg_wdata[`APEM_F_TXMUTE];
               st_nxt.rx_mute_en = reg_wdata[`APEM_F_RXMUTE];
               st_nxt.mute_low   = reg_wdata[`APEM_F_MUTELOW];
               st_nxt.in_pol_low = reg_wdata[`APEM_F_INPOLLOW];
               st_nxt.in_en      = reg_wdata[`APEM_F_INEN];
            end
            `APEM_OFF_CFG: begin
               st_nxt.tdm       = reg_wdata[`APEM_F_TDM];
               st_nxt.biphase   = reg_wdata[`APEM_F_BIPHASE];
               st_nxt.frame_len = reg_wdata[`APEM_F_FLEN];
            end
            default: ;
         endcase
      end

      st_nxt.rdata = '0;
      if (reg_rd) begin
         unique case (reg_addr)
            `APEM_OFF_TXCHK: st_nxt.rdata = {tx_count, 4'h0, st_r.tx_chk.sw, st_r.tx_chk.ps,
                                             st_r.tx_chk.max_b, st_r.tx_chk.min_b};
            `APEM_OFF_RXCHK: st_nxt.rdata = {rx_count, 5'h00, st_r.rx_chk.ps,
                                             st_r.rx_chk.max_b, st_r.rx_chk.min_b};
            `APEM_OFF_TXSTAT: st_nxt.rdata = {28'h000_0000, st_r.tx_stat};
            `APEM_OFF_RXSTAT: st_nxt.rdata = {28'h000_0000, st_r.rx_stat};
            `APEM_OFF_TXINT:  st_nxt.rdata = {28'h000_0000, st_r.tx_ie};
            `APEM_OFF_RXINT:  st_nxt.rdata = {28'h000_0000, st_r.rx_ie};
            `APEM_OFF_MUTE:   st_nxt.rdata = {21'h00_0000, st_r.in_en, st_r.in_pol_low,
                                              st_r.mute_low, st_r.rx_mute_en, st_r.tx_mute_en};
            `APEM_OFF_CFG:    st_nxt.rdata = {5'h00, st_r.frame_len, 12'h000, st_r.zero_fill,
                                              1'b0, st_r.biphase, st_r.tdm};
            default: st_nxt.rdata = '0;
         endcase
      end
   end

   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         st_r <= '0;
      end else begin
         st_r <= st_nxt;
      end
   end

   assign reg_rdata     = st_r.rdata;
   assign tx_irq        = st_r.tx_irq;
   assign rx_irq        = st_r.rx_irq;
   assign mute_output   = st_r.mute;
   assign tx_clk_switch = st_r.clk_switch;
   assign tx_zero_fill  = st_r.zero_fill;

   underrun_set_a: assert property (@(posedge clk) disable iff (!arst_n) // see [RULE_14]
      (tx_link.slot_xfer && |(tx_link.ser_en & ~st_r.tx_written))
         |=> st_r.tx_stat[`APEM_ST_XRUN])
      else $error("underrun not flagged");

   overrun_sticky_a: assert property (@(posedge clk) disable iff (!arst_n) // see [RULE_19]
      (st_r.rx_stat[`APEM_ST_XRUN] && !(reg_wr && reg_addr == `APEM_OFF_RXSTAT
         && reg_wdata[`APEM_ST_XRUN])) |=> st_r.rx_stat[`APEM_ST_XRUN])
      else $error("overrun flag dropped without clear");

   early_sync_a: assert property (@(posedge clk) disable iff (!arst_n) // see [RULE_11]
      (tx_link.bit_tick && tx_link.fsync && st_r.tx_fr.active
         && st_r.tx_fr.pos != st_r.frame_len)
         |=> (st_r.tx_stat[`APEM_ST_SYNC] && st_r.tx_fr.wait_rs
              && st_r.tx_fr.pos == $past(st_r.tx_fr.pos) + 11'h001))
      else $error("early sync not flagged or frame resynced");

   dma_extra_a: assert property (@(posedge clk) disable iff (!arst_n) // see [RULE_20]
      (tx_link.dma_acc && !tx_link.dma_req && st_r.tx_words >= ones(tx_link.ser_en))
         |=> st_r.tx_stat[`APEM_ST_DMA])
      else $error("extra dma word not flagged");

   irq_gate_a: assert property (@(posedge clk) disable iff (!arst_n) // see [RULE_23]
      (st_r.rx_ie == 4'h0 && $past(st_r.rx_ie) == 4'h0) |-> !st_r.rx_irq)
      else $error("receive interrupt without enable");

   mute_input_a: assert property (@(posedge clk) disable iff (!arst_n) // see [RULE_22]
      (st_r.in_en && (external_mute_input ^ st_r.in_pol_low))[*4]
         |-> (mute_output == !st_r.mute_low))
      else $error("mute input did not drive mute");

   zero_hold_a: assert property (@(posedge clk) disable iff (!arst_n) // see [RULE_17]
      (st_r.zero_hold && !restart) |=> (tx_zero_fill && st_r.zero_hold))
      else $error("tdm zero fill released without restart");
endmodule // apem_err_mon

// ---- rtl/apem_pkg.sv ----
// apem_pkg: types shared by the audio port error monitor
// assumes: apem_cfg.svh sits on the include path
`include "apem_cfg.svh"
package apem_pkg;

   typedef struct packed {
      logic                   bit_tick;
      logic                   fsync;
      logic                   slot_xfer;
      logic [`APEM_NSER-1:0]  ser_en;
      logic [`APEM_NSER-1:0]  buf_acc;
      logic                   dma_req;
      logic                   dma_acc;
   } apem_dir_in_s;

   typedef struct packed {
      logic [7:0] min_b;
      logic [7:0] max_b;
      logic [2:0] ps;
      logic       sw;
   } apem_chk_s;

   typedef struct packed {
      logic [10:0] pos;
      logic        active;
      logic        wait_rs;
   } apem_frame_s;

   typedef struct packed {
      logic [7:0] run_cnt;
      logic [7:0] count;
      logic [6:0] pre;
      logic [4:0] edges;
      logic       hf_d;
      logic       fail;
   } apem_mon_s;

   typedef struct packed {
      logic [1:0] q;
   } apem_sync_s;

endpackage

// ---- rtl/apem_sync2.sv ----
// apem_sync2: two-flop synchroniser for one level from outside the clk domain
// assumes: d may change at any time relative to clk
`timescale 1ns/1ps
module apem_sync2 (
   input  wire logic clk,
   input  wire logic arst_n,
   input  wire logic d,
   output logic      q
);
   import apem_pkg::*;
   apem_sync_s s_r;
   apem_sync_s s_nxt;

   always_comb begin
      s_nxt = {s_r.q[0], d};
   end

   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         s_r <= '0;
      end else begin
         s_r <= s_nxt;
      end
   end

   assign q = s_r.q[1];
endmodule // apem_sync2

// ---- testbench/apem_dma_model.sv ----
// apem_dma_model: dma master that writes transmit buffers of the monitor
// assumes: go is a one-clk pulse, n words then follow one every second clk
`timescale 1ns/1ps
module apem_dma_model (
   input  wire logic       clk,
   input  wire logic       go,
   input  wire logic [2:0] n,
   output logic [3:0]      buf_acc,
   output logic            dma_acc
);
   logic [2:0] left_r = 3'h0;
   initial begin
      buf_acc = 4'h0;
      dma_acc = 1'h0;
   end
   // one word per enabled serializer, more only when the bench asks
   always @(posedge clk) begin
      if (go) begin
         left_r <= n;
      end else if (left_r != 3'h0 && !dma_acc) begin
         dma_acc <= 1'h1;
         buf_acc <= 4'h1;
         left_r  <= left_r - 3'h1;
      end else begin
         dma_acc <= 1'h0;
         buf_acc <= 4'h0;
      end
   end
endmodule // apem_dma_model

// ---- testbench/apem_err_mon_tb.sv ----
// apem_err_mon_tb: self-checking bench of the audio port error monitor
// assumes: apem_pkg compiled first; serial clocks free-run at 400 ns
`timescale 1ns/1ps
module apem_err_mon_tb;
   import apem_pkg::*;
   logic         clk = 1'h0, arst_n = 1'h0, wr = 1'h0, rd = 1'h0;
   logic         thf = 1'h0, rhf = 1'h0, mi = 1'h0, go = 1'h0;
   logic [2:0]   nw = 3'h0;
   logic [7:0]   addr = 8'h00;
   logic [31:0]  wdata = 32'h0000_0000, rdata;
   logic [3:0]   pb;
   logic         pd, tx_irq, rx_irq, mute_output, tx_sw, zf;
   apem_dir_in_s tl = '0, rl = '0, tx_in;
   int           error_cnt = 0, comparisons = 0;
   always #25 clk = ~clk;
   initial #13 forever #200 thf = ~thf;
   initial #91 forever #200 rhf = ~rhf;
   always_comb begin
      tx_in = tl;
      tx_in.buf_acc = pb;
      tx_in.dma_acc = pd;
   end
   apem_dma_model dma_m (.clk(clk), .go(go), .n(nw), .buf_acc(pb), .dma_acc(pd));
   apem_err_mon dut (.clk(clk), .arst_n(arst_n), .reg_addr(addr), .reg_wdata(wdata),
      .reg_wr(wr), .reg_rd(rd), .reg_rdata(rdata), .tx_hf_serial_clock(thf),
      .rx_hf_serial_clock(rhf), .external_mute_input(mi), .tx_link(tx_in), .rx_link(rl),
      .tx_irq(tx_irq), .rx_irq(rx_irq), .mute_output(mute_output), .tx_clk_switch(tx_sw),
      .tx_zero_fill(zf));
   task automatic chk(input logic [31:0] g, input logic [31:0] e);
      comparisons++;
      if (g !== e) begin
         error_cnt++;
         $display("[ERR] t=%0t got=%h exp=%h", $time, g, e);
      end
   endtask
   task automatic chk_rng(input logic [31:0] g, input logic [31:0] lo, input logic [31:0] hi);
      comparisons++;
      if ((g >= lo && g <= hi) !== 1'b1) begin
         error_cnt++;
         $display("[ERR] t=%0t got=%h exp=%h..%h", $time, g, lo, hi);
      end
   endtask
   task automatic wr32(input logic [7:0] a, input logic [31:0] d);
      @(posedge clk);
      addr <= a;
      wdata <= d;
      wr <= 1'h1;
      @(posedge clk);
      wr <= 1'h0;
   endtask
   task automatic rd32(input logic [7:0] a, output logic [31:0] d);
      @(posedge clk);
      addr <= a;
      rd <= 1'h1;
      @(posedge clk);
      rd <= 1'h0;
      @(negedge clk);
      d = rdata;
      @(posedge clk);
   endtask
   task automatic xfer(input bit rx);
      @(posedge clk);
      if (rx) rl.slot_xfer <= 1'h1;
      else tl.slot_xfer <= 1'h1;
      @(posedge clk);
      rl.slot_xfer <= 1'h0;
      tl.slot_xfer <= 1'h0;
      rl.buf_acc <= 4'h0;
      repeat (2) @(posedge clk);
   endtask
   task automatic dma(input logic [2:0] n);
      @(posedge clk);
      go <= 1'h1;
      nw <= n;
      tl.dma_req <= 1'h1;
      @(posedge clk);
      go <= 1'h0;
      tl.dma_req <= 1'h0;
      repeat (8) @(posedge clk);
   endtask
   task automatic tick(input logic fs);
      @(posedge clk);
      tl.bit_tick <= 1'h1;
      tl.fsync <= fs;
      @(posedge clk);
      tl.bit_tick <= 1'h0;
      tl.fsync <= 1'h0;
   endtask
   task automatic t_xrun;
      logic [31:0] d;
      rd32(8'h40, d);
      chk(d, 32'h0000_0000);
      wr32(8'h10, 32'h0000_0001);
      wr32(8'h18, 32'h0000_0001);
      tl.ser_en <= 4'h1;
      xfer(0);
      rd32(8'h08, d);
      chk(d[0], 1'h1);
      chk({tx_irq, mute_output}, 2'h3);
      wr32(8'h08, 32'h0000_0001);
      repeat (6) @(posedge clk);
      rd32(8'h08, d);
      chk({d[0], tx_irq, mute_output}, 3'h0);
      dma(3'h1);
      xfer(0);
      rd32(8'h08, d);
      chk({d[3], d[0]}, 2'h0);
      dma(3'h2);
      rd32(8'h08, d);
      chk(d[3], 1'h1);
      wr32(8'h18, 32'h0000_0400);
      mi <= 1'h1;
      repeat (6) @(posedge clk);
      chk(mute_output, 1'h1);
      mi <= 1'h0;
      repeat (6) @(posedge clk);
      chk(mute_output, 1'h0);
      $display("test underrun dma mute done");
   endtask
   task automatic t_orun;
      logic [31:0] d;
      rl.ser_en <= 4'h1;
      xfer(1);
      xfer(1);
      rd32(8'h0C, d);
      chk(d[0], 1'h1);
      rl.buf_acc <= 4'h1;
      xfer(1);
      rd32(8'h0C, d);
      chk({d[0], rx_irq}, 2'h2);
      wr32(8'h0C, 32'h0000_0001);
      rd32(8'h0C, d);
      chk(d[0], 1'h0);
      // one receive dma request, two words read with one serializer enabled
      rl.dma_req <= 1'h1;
      @(posedge clk);
      rl.dma_req <= 1'h0;
      rl.dma_acc <= 1'h1;
      repeat (2) @(posedge clk);
      rl.dma_acc <= 1'h0;
      rd32(8'h0C, d);
      chk(d[3], 1'h1);
      $display("test overrun done");
   endtask
   task automatic t_sync;
      logic [31:0] d;
      wr32(8'h1C, 32'h0004_0000);
      tick(1);
      tick(0);
      tick(1);
      rd32(8'h08, d);
      chk(d[1], 1'h1);
      wr32(8'h08, 32'h0000_0002);
      tick(0);
      tick(0);
      tick(1);
      repeat (3) tick(0);
      tick(1);
      rd32(8'h08, d);
      chk(d[1], 1'h0);
      repeat (4) tick(0);
      rd32(8'h08, d);
      chk(d[1], 1'h1);
      $display("test frame sync done");
   endtask
   task automatic t_clk;
      logic [31:0] d;
      // prescale 1: 32 periods of 8 clk give a count near 128
      for (int i = 0; i < 2; i++) begin
         wr32(8'(i * 4), 32'h0001_FF70);
         repeat (700) @(posedge clk);
         wr32(8'(8 + i * 4), 32'h0000_0004);
         repeat (700) @(posedge clk);
         rd32(8'(i * 4), d);
         chk_rng(d[31:24], 8'h7E, 8'h82);
         rd32(8'(8 + i * 4), d);
         chk(d[2], 1'h0);
         wr32(8'(i * 4), 32'h0009_FFC8);
         repeat (700) @(posedge clk);
         rd32(8'(8 + i * 4), d);
         chk(d[2], 1'h1);
      end
      chk(tx_sw, 1'h1);
      wr32(8'h10, 32'h0000_0000);
      repeat (2) @(posedge clk);
      chk(tx_irq, 1'h0);
      wr32(8'h10, 32'h0000_0004);
      repeat (2) @(posedge clk);
      chk(tx_irq, 1'h1);
      $display("test clock monitor done");
   endtask
   task automatic t_zero;
      // biphase: the first load still has a written buffer, the second underruns
      wr32(8'h1C, 32'h0000_0002);
      xfer(0);
      chk(zf, 1'h0);
      xfer(0);
      repeat (3) tick(0);
      @(posedge clk);
      chk(zf, 1'h1);
      tick(0);
      @(posedge clk);
      chk(zf, 1'h0);
      // tdm: zeros hold until the restart write
      wr32(8'h1C, 32'h0000_0001);
      xfer(0);
      repeat (5) tick(0);
      @(posedge clk);
      chk(zf, 1'h1);
      wr32(8'h1C, 32'h0000_0005);
      @(posedge clk);
      chk(zf, 1'h0);
      $display("test zero fill done");
   endtask
   task automatic summarize;
      $display("comparisons=%0d errors=%0d", comparisons, error_cnt);
      if (error_cnt == 0 && comparisons > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
   endtask
   initial begin
      #500000;
      error_cnt++;
      summarize();
   end
   initial begin
      repeat (5) @(posedge clk);
      arst_n <= 1'h1;
      t_xrun();
      t_orun();
      t_sync();
      t_zero();
      t_clk();
      summarize();
   end
endmodule // apem_err_mon_tb
